// ### scan_tap_timing.sv
// Test access port: controller, instruction, bypass and data paths
//
// Functional notes
// RULE1: All scan logic is clocked by the test clock alone.
// RULE2: Mode, serial input and functional inputs are sampled on rising edge.
// RULE3: Serial output and test-driven outputs change only on falling edge.
// RULE4: Controller changes mode select on falling edges.
// RULE5: Mode low in reset state moves to idle on next rising edge.
// RULE6: Instruction register captures 10000001 leaving instruction capture.
// RULE7: Serial output driver enables on falling edge after entering shift.
// RULE8: Controller presents serial data on falling edges.
// RULE9: One instruction bit shifts in per rising edge in instruction shift.
// RULE10: Captured instruction value leaves serially while new bits enter.
// RULE11: Mode high in last shift cycle shifts final bit and exits.
// RULE12: Serial output returns to high impedance on falling edge in exit1.
// RULE13: Instruction updates on falling edge in update; all-ones is bypass.
// RULE14: Bypass register captures zero leaving data capture when bypassed.
// RULE15: Bypass path is one stage; 101 in gives 010 out.
// RULE16: Selected data register updates on falling edge in data update.
// RULE17: Standard sixteen states; five high mode edges reach reset state.
`timescale 1ns/1ps
`default_nettype none

module scan_tap_timing #(
  parameter int unsigned DR_W = scan_tap_pkg::DR_WIDTH
) (
  // System clock and reset
  input  wire  logic            clk_sys,
  input  wire  logic            rstn,
  // Test port pins
  input  wire  logic            tck,
  input  wire  logic            tms,
  input  wire  logic            tdi,
  output var   logic            tdo,
  output var   logic            tdoEnN,
  // Functional pins seen by the data register
  input  wire  logic [DR_W-1:0] funcIn,
  output var   logic [DR_W-1:0] funcOut,
  // Status in the system clock domain
  output var   logic            bypassSel,
  output var   logic            testReset
);

  // ==========================================================
  // Reset carried into the test clock domain
  // ==========================================================
  // Two stages; the port may also be reset by the mode line
  logic rstSync1_q;
  logic tckRstn;

  always_ff @(posedge tck) begin
    rstSync1_q <= rstn;
    tckRstn    <= rstSync1_q;
  end

  // ==========================================================
  // Functional input pins, synchronised to the test clock
  // ==========================================================
  logic [DR_W-1:0] funcS1_q;
  logic [DR_W-1:0] funcS2_q;

  always_ff @(posedge tck) begin
    funcS1_q <= funcIn;
    funcS2_q <= funcS1_q;
  end

  // ==========================================================
  // Controller state, rising edge
  // ==========================================================
  scan_tap_pkg::tap_state_t state_q;
  scan_tap_pkg::tap_state_t state_d;

  // RULE17: standard state walk
  assign state_d = scan_tap_pkg::tapNext(state_q, tms);

  // RULE5: mode sampled on rising edge
  always_ff @(posedge tck) begin
    if (!tckRstn) begin
      state_q <= scan_tap_pkg::ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // Instruction shift stage, rising edge
  // ==========================================================
  logic [scan_tap_pkg::IR_WIDTH-1:0] irShift_q;
  logic [scan_tap_pkg::IR_WIDTH-1:0] irActive_q;
  logic                              bypassOn;

  // RULE13: all-ones code selects bypass
  assign bypassOn = (irActive_q == scan_tap_pkg::INSTR_BYPASS);

  // RULE6: fixed capture; RULE9: one bit per edge, LSB first out
  // RULE11: exit edge still shifts
  always_ff @(posedge tck) begin
    if (!tckRstn) begin
      irShift_q <= scan_tap_pkg::IR_CAPTURE_VAL;
    end else if (state_q == scan_tap_pkg::ST_CAP_IR) begin
      irShift_q <= scan_tap_pkg::IR_CAPTURE_VAL;
    end else if (state_q == scan_tap_pkg::ST_SHIFT_IR) begin
      irShift_q <= {tdi, irShift_q[scan_tap_pkg::IR_WIDTH-1:1]};
    end
  end

  // ==========================================================
  // Active instruction, falling edge
  // ==========================================================
  // Falling-edge update keeps the new instruction clear of the
  // rising edge that samples the mode line.
  // Registered bypass decode; a compare of eight bits may glitch,
  // so only this flop is handed to the system clock domain.
  logic bypassLvl_q;

  // RULE13: transfer in update state
  always_ff @(negedge tck) begin
    if (!tckRstn || state_q == scan_tap_pkg::ST_RESET) begin
      irActive_q  <= scan_tap_pkg::INSTR_RESET;
      bypassLvl_q <= (scan_tap_pkg::INSTR_RESET ==
                      scan_tap_pkg::INSTR_BYPASS);
    end else if (state_q == scan_tap_pkg::ST_UPD_IR) begin
      irActive_q  <= irShift_q;
      bypassLvl_q <= (irShift_q == scan_tap_pkg::INSTR_BYPASS);
    end
  end

  // ==========================================================
  // Bypass register, rising edge
  // ==========================================================
  logic bypass_q;

  // RULE14: zero capture; RULE15: single stage from serial input
  always_ff @(posedge tck) begin
    if (!tckRstn) begin
      bypass_q <= scan_tap_pkg::BYPASS_CAPTURE;
    end else if (bypassOn && state_q == scan_tap_pkg::ST_CAP_DR) begin
      bypass_q <= scan_tap_pkg::BYPASS_CAPTURE;
    end else if (bypassOn && state_q == scan_tap_pkg::ST_SHIFT_DR) begin
      bypass_q <= tdi;
    end
  end

  // ==========================================================
  // Data register for every non-bypass code, rising edge
  // ==========================================================
  logic [DR_W-1:0] drShift_q;

  // RULE2: functional inputs captured on the rising edge
  always_ff @(posedge tck) begin
    if (!tckRstn) begin
      drShift_q <= DR_W'(scan_tap_pkg::DR_RESET_VAL);
    end else if (!bypassOn && state_q == scan_tap_pkg::ST_CAP_DR) begin
      drShift_q <= funcS2_q;
    end else if (!bypassOn && state_q == scan_tap_pkg::ST_SHIFT_DR) begin
      drShift_q <= {tdi, drShift_q[DR_W-1:1]};
    end
  end

  // ==========================================================
  // Data update to functional outputs, falling edge
  // ==========================================================
  // RULE16: shadow update in data update state
  always_ff @(negedge tck) begin
    if (!tckRstn) begin
      funcOut <= DR_W'(scan_tap_pkg::DR_RESET_VAL);
    end else if (!bypassOn && state_q == scan_tap_pkg::ST_UPD_DR) begin
      funcOut <= drShift_q;
    end
  end

  // ==========================================================
  // Serial output and its enable, falling edge
  // ==========================================================
  // RULE3: output bit moves only on the falling edge
  always_ff @(negedge tck) begin
    if (!tckRstn) begin
      tdo <= scan_tap_pkg::TDO_RESET_VAL;
    end else if (state_q == scan_tap_pkg::ST_SHIFT_IR) begin
      // RULE10: captured value leaves LSB first
      tdo <= irShift_q[0];
    end else if (state_q == scan_tap_pkg::ST_SHIFT_DR) begin
      tdo <= bypassOn ? bypass_q : drShift_q[0];
    end
  end

  // RULE7: enable in shift; RULE12: release in exit1 and elsewhere
  always_ff @(negedge tck) begin
    if (!tckRstn) begin
      tdoEnN <= 1'b1;
    end else begin
      tdoEnN <= !scan_tap_pkg::isShift(state_q);
    end
  end

  // ==========================================================
  // Status levels crossed into the system clock domain
  // ==========================================================
  // RULE1: status is observation only, scan never waits on clk_sys
  logic bypassS1_q;
  logic resetS1_q;
  logic inReset_q;

  always_ff @(posedge tck) begin
    if (!tckRstn) begin
      inReset_q <= 1'b1;
    end else begin
      inReset_q <= (state_d == scan_tap_pkg::ST_RESET);
    end
  end

  // Two-flop synchronisers, one per level
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      bypassS1_q <= 1'b1;
      bypassSel  <= 1'b1;
      resetS1_q  <= 1'b1;
      testReset  <= 1'b1;
    end else begin
      bypassS1_q <= bypassLvl_q;
      bypassSel  <= bypassS1_q;
      resetS1_q  <= inReset_q;
      testReset  <= resetS1_q;
    end
  end

  // ==========================================================
  // Checks on the test clock domain
  // ==========================================================
  // Five consecutive rising edges with the mode line high
  sequence s_tmsHigh5;
    tms [*5];
  endsequence

  // Exit from instruction shift with the final bit taken
  sequence s_lastIrBit;
    (state_q == scan_tap_pkg::ST_SHIFT_IR) && tms;
  endsequence

  property p_resetWalk;
    @(posedge tck) disable iff (!tckRstn)
    s_tmsHigh5 |=> (state_q == scan_tap_pkg::ST_RESET);
  endproperty
  a_resetWalk: assert property (p_resetWalk) // RULE17
    else $error("five high mode edges did not reach reset");

  property p_leaveReset;
    @(posedge tck) disable iff (!tckRstn)
    (state_q == scan_tap_pkg::ST_RESET) && !tms
      |=> (state_q == scan_tap_pkg::ST_IDLE);
  endproperty
  a_leaveReset: assert property (p_leaveReset) // RULE5
    else $error("reset state did not move to idle");

  property p_irCapture;
    @(posedge tck) disable iff (!tckRstn)
    (state_q == scan_tap_pkg::ST_CAP_IR)
      |=> (irShift_q == scan_tap_pkg::IR_CAPTURE_VAL);
  endproperty
  a_irCapture: assert property (p_irCapture) // RULE6
    else $error("instruction capture pattern wrong");

  property p_irShift;
    @(posedge tck) disable iff (!tckRstn)
    (state_q == scan_tap_pkg::ST_SHIFT_IR)
      |=> (irShift_q == {$past(tdi), $past(irShift_q[7:1])});
  endproperty
  a_irShift: assert property (p_irShift) // RULE9
    else $error("instruction shift moved wrong bit");

  property p_lastBit;
    @(posedge tck) disable iff (!tckRstn)
    s_lastIrBit |=> (state_q == scan_tap_pkg::ST_EXIT1_IR)
      && (irShift_q[7] == $past(tdi));
  endproperty
  a_lastBit: assert property (p_lastBit) // RULE11
    else $error("final instruction bit or exit lost");

  property p_irOut;
    @(posedge tck) disable iff (!tckRstn)
    (state_q == scan_tap_pkg::ST_SHIFT_IR) |-> (tdo == irShift_q[0]);
  endproperty
  a_irOut: assert property (p_irOut) // RULE10
    else $error("serial output not the instruction LSB");

  property p_enableShift;
    @(posedge tck) disable iff (!tckRstn)
    scan_tap_pkg::isShift(state_q) |-> !tdoEnN;
  endproperty
  a_enableShift: assert property (p_enableShift) // RULE7
    else $error("serial output not driven in shift");

  property p_releaseExit;
    @(posedge tck) disable iff (!tckRstn)
    (state_q == scan_tap_pkg::ST_EXIT1_IR ||
     state_q == scan_tap_pkg::ST_EXIT1_DR) |-> tdoEnN;
  endproperty
  a_releaseExit: assert property (p_releaseExit) // RULE12
    else $error("serial output still driven in exit1");

  property p_irUpdate;
    @(posedge tck) disable iff (!tckRstn)
    (state_q == scan_tap_pkg::ST_UPD_IR) |-> (irActive_q == irShift_q);
  endproperty
  a_irUpdate: assert property (p_irUpdate) // RULE13
    else $error("instruction not updated on falling edge");

  property p_bypassCapture;
    @(posedge tck) disable iff (!tckRstn)
    bypassOn && (state_q == scan_tap_pkg::ST_CAP_DR) |=> !bypass_q;
  endproperty
  a_bypassCapture: assert property (p_bypassCapture) // RULE14
    else $error("bypass register did not capture zero");

  property p_bypassPath;
    @(posedge tck) disable iff (!tckRstn)
    bypassOn && (state_q == scan_tap_pkg::ST_SHIFT_DR)
      ##1 (state_q == scan_tap_pkg::ST_SHIFT_DR)
      |-> (tdo == $past(tdi));
  endproperty
  a_bypassPath: assert property (p_bypassPath) // RULE15
    else $error("bypass path not one stage");

  property p_drUpdate;
    @(posedge tck) disable iff (!tckRstn)
    !bypassOn && (state_q == scan_tap_pkg::ST_UPD_DR)
      |-> (funcOut == drShift_q);
  endproperty
  a_drUpdate: assert property (p_drUpdate) // RULE16
    else $error("data register not updated on falling edge");

  property p_drOut;
    @(posedge tck) disable iff (!tckRstn)
    !bypassOn && (state_q == scan_tap_pkg::ST_SHIFT_DR)
      |-> (tdo == drShift_q[0]);
  endproperty
  a_drOut: assert property (p_drOut) // RULE3
    else $error("serial output not the data register LSB");

  property p_funcHold;
    @(posedge tck) disable iff (!tckRstn)
    (state_q != scan_tap_pkg::ST_UPD_DR) |-> $stable(funcOut);
  endproperty
  a_funcHold: assert property (p_funcHold) // RULE16
    else $error("functional outputs moved outside data update");

endmodule

`default_nettype wire

// ### scan_tap_pkg.sv
// Shared constants, state type and state walk for the scan port
`default_nettype none

package scan_tap_pkg;

  // ==========================================================
  // Widths and fixed values
  // ==========================================================
  localparam int unsigned IR_WIDTH = 8;
  localparam int unsigned DR_WIDTH = 8;
  // Pattern loaded when the instruction scan captures
  localparam logic [7:0] IR_CAPTURE_VAL = 8'h81;
  // All-ones code selects the one-bit bypass path
  localparam logic [7:0] INSTR_BYPASS   = 8'hff;
  // Instruction in force after the port is reset
  localparam logic [7:0] INSTR_RESET    = 8'hff;
  localparam logic       BYPASS_CAPTURE = 1'b0;
  localparam logic [7:0] DR_RESET_VAL   = 8'h00;
  localparam logic       TDO_RESET_VAL  = 1'b0;
  localparam int unsigned TMS_RESET_EDGES = 5;

  // ==========================================================
  // Controller states
  // ==========================================================
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE,
    ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
    ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
    ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } tap_state_t;

  // ==========================================================
  // Sixteen-state walk driven by the mode select line
  // ==========================================================
  function automatic tap_state_t tapNext(input tap_state_t s,
                                         input logic mode);
    tap_state_t n;
    n = ST_RESET;
    case (s)
      ST_RESET:    n = mode ? ST_RESET    : ST_IDLE;
      ST_IDLE:     n = mode ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR:   n = mode ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   n = mode ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: n = mode ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: n = mode ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: n = mode ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: n = mode ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   n = mode ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR:   n = mode ? ST_RESET    : ST_CAP_IR;
      ST_CAP_IR:   n = mode ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: n = mode ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: n = mode ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: n = mode ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: n = mode ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   n = mode ? ST_SEL_DR   : ST_IDLE;
      default:     n = ST_RESET;
    endcase
    return n;
  endfunction

  // True in either shift state
  function automatic logic isShift(input tap_state_t s);
    return (s == ST_SHIFT_DR) || (s == ST_SHIFT_IR);
  endfunction

endpackage

`default_nettype wire

// ### scan_ctrl_model.sv
// Behavioural test controller that drives the scan port pins
`timescale 1ns/1ps
`default_nettype none

module scan_ctrl_model (
  // Pins driven toward the device
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi,
  // Pins returned by the device
  input  wire logic tdo,
  input  wire logic tdoEnN
);
  // Values seen just after the last falling edge
  logic seenTdo;
  logic seenEnN;

  // Clock stands low between cycles
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    seenTdo = 1'b0;
    seenEnN = 1'b1;
  end

  // ==========================================================
  // One test clock cycle of 32 ns
  // ==========================================================
  // pins set while the clock is low
  task automatic step(input logic m, input logic d);
    tms = m;
    tdi = d;
    #15 tck = 1'b1;
    #16 tck = 1'b0;
    #1;
    // Released pin reads inverted, so a late enable spoils the bit
    seenTdo = tdoEnN ? ~tdo : tdo;
    seenEnN = tdoEnN;
  endtask

  // Data keeps toggling outside shifts so no stale bit looks valid
  task automatic move(input logic m);
    step(m, ~tdi);
  endtask
endmodule

`default_nettype wire

// ### scan_tap_timing_tb_top.sv
// Self-checking bench for the scan port timing block
`timescale 1ns/1ps
`default_nettype none

module scan_tap_timing_tb_top;
  localparam int LIMIT = 6000;
  logic       clkSys;
  logic       rstn;
  logic       tck;
  logic       tms;
  logic       tdi;
  logic       tdo;
  logic       tdoEnN;
  logic [7:0] funcIn;
  logic [7:0] funcOut;
  logic       bypassSel;
  logic       testReset;
  int         nFail;
  int         checked;
  int         cycles;
  logic [7:0] d;

  scan_tap_timing i_scan_tap_timing (
    .clk_sys   (clkSys),
    .rstn      (rstn),
    .tck       (tck),
    .tms       (tms),
    .tdi       (tdi),
    .tdo       (tdo),
    .tdoEnN    (tdoEnN),
    .funcIn    (funcIn),
    .funcOut   (funcOut),
    .bypassSel (bypassSel),
    .testReset (testReset)
  );

  scan_ctrl_model i_scan_ctrl_model (
    .tck    (tck),
    .tms    (tms),
    .tdi    (tdi),
    .tdo    (tdo),
    .tdoEnN (tdoEnN)
  );

  // ==========================================================
  // Clock, timeout and reporting
  // ==========================================================
  // System clock, 5 ns period
  always #2.5 clkSys = ~clkSys;

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // A hung scan sequence ends the run here
  always @(posedge clkSys) begin
    cycles = cycles + 1;
    if (cycles == LIMIT) begin
      nFail = nFail + 1;
      give_verdict();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    checked = checked + 1;
    if (seen !== exp) begin
      nFail = nFail + 1;
      $display("CHECK FAILED at %0t: %s seen %h expected %h",
               $time, what, seen, exp);
    end
  endtask

  // ==========================================================
  // Shared scan from idle back to idle, LSB first
  // ==========================================================
  task automatic scan(input logic isIr, input int n, input logic [7:0] din,
                      output logic [7:0] dout);
    dout = 8'h00;
    i_scan_ctrl_model.move(1'b1);
    if (isIr)
      i_scan_ctrl_model.move(1'b1);
    i_scan_ctrl_model.move(1'b0);
    i_scan_ctrl_model.move(1'b0);
    dout[0] = i_scan_ctrl_model.seenTdo;
    check(i_scan_ctrl_model.seenEnN, 1'b0, "driver on");
    for (int i = 0; i < n; i++) begin
      i_scan_ctrl_model.step(i == n - 1, din[i]);
      if (i < n - 1) begin
        dout[i+1] = i_scan_ctrl_model.seenTdo;
        check(i_scan_ctrl_model.seenEnN, 1'b0, "driver held");
      end
    end
    check(i_scan_ctrl_model.seenEnN, 1'b1, "driver off");
    i_scan_ctrl_model.move(1'b1);
    i_scan_ctrl_model.move(1'b0);
    repeat (4) @(posedge clkSys);
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  // Reset levels at the pins and status outputs
  task automatic t_reset();
    check(testReset, 1'b1, "reset state");
    check(bypassSel, 1'b1, "reset instr");
    check(tdoEnN, 1'b1, "driver idle");
    check(funcOut, 8'h00, "outputs reset");
  endtask

  // Leave reset, load all-ones, read back the capture pattern
  task automatic t_ir_bypass();
    i_scan_ctrl_model.move(1'b0);
    repeat (4) @(posedge clkSys);
    check(testReset, 1'b0, "left reset");
    // Leave bypass first so the later bypass check can trip
    scan(1'b1, 8, 8'h5a, d);
    check(bypassSel, 1'b0, "bypass off first");
    scan(1'b1, 8, scan_tap_pkg::INSTR_BYPASS, d);
    check(d, scan_tap_pkg::IR_CAPTURE_VAL, "ir out");
    check(bypassSel, 1'b1, "bypass on");
  endtask

  // One-stage bypass path: 101 in gives 010 out
  task automatic t_bypass();
    scan(1'b0, 3, 8'h05, d);
    check({5'h00, d[2:0]}, 8'h02, "bypass out");
  endtask

  // Data register captures inputs and updates outputs
  task automatic t_data();
    @(posedge clkSys);
    #1 funcIn = 8'hc3;
    scan(1'b1, 8, 8'h5a, d);
    check(d, scan_tap_pkg::IR_CAPTURE_VAL, "ir out again");
    check(bypassSel, 1'b0, "bypass off");
    check(funcOut, 8'h00, "outputs held");
    scan(1'b0, 8, 8'h3c, d);
    check(d, 8'hc3, "captured inputs");
    check(funcOut, 8'h3c, "outputs updated");
  endtask

  // Five high mode edges from a paused scan reach reset
  task automatic t_tlr();
    i_scan_ctrl_model.move(1'b1);
    i_scan_ctrl_model.move(1'b0);
    i_scan_ctrl_model.move(1'b0);
    i_scan_ctrl_model.move(1'b1);
    i_scan_ctrl_model.move(1'b0);
    check(testReset, 1'b0, "paused");
    repeat (5) i_scan_ctrl_model.move(1'b1);
    repeat (4) @(posedge clkSys);
    check(testReset, 1'b1, "back in reset");
    check(bypassSel, 1'b1, "instr reset");
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    clkSys = 1'b0;
    rstn = 1'b0;
    funcIn = 8'h00;
    nFail = 0;
    checked = 0;
    cycles = 0;
    repeat (10) @(posedge clkSys);
    // Test clock must run while reset is held
    repeat (5) i_scan_ctrl_model.move(1'b1);
    @(posedge clkSys);
    #1 rstn = 1'b1;
    repeat (3) i_scan_ctrl_model.move(1'b1);
    repeat (4) @(posedge clkSys);
    t_reset();
    t_ir_bypass();
    t_bypass();
    t_data();
    t_tlr();
    give_verdict();
  end
endmodule

`default_nettype wire
